// ==== hw/pll_dividers_pkg.sv ====
// constants, field layout and state carrier for the serial-programmed pll divider block
// assumes a 10 MHz system clock; the serial, chip enable, reference and rf pins arrive asynchronously to it
package pll_dividers_pkg;

  // ---------------------------------------------------------------
  // word and counter widths
  // ---------------------------------------------------------------
  localparam int SHIFT_W = 24;
  localparam int R_W     = 14;
  localparam int N_W     = 13;
  localparam int ADDR_W  = 8;
  localparam int ERR_W   = 8;
  localparam int GOOD_W  = 3;

  // ---------------------------------------------------------------
  // latch field positions
  // ---------------------------------------------------------------
  localparam int SEL_LSB      = 0;
  localparam int R_LSB        = 2;
  localparam int LOCK_PREC    = 20;
  localparam int N_LSB        = 8;
  localparam int CTR_RST_BIT  = 2;
  localparam int PWRDN_BIT    = 3;
  localparam int MUX_LSB      = 4;
  localparam int CP_TRI_BIT   = 8;

  localparam logic [1:0] SEL_REF  = 2'h0;
  localparam logic [1:0] SEL_FB   = 2'h1;
  localparam logic [1:0] SEL_FUNC = 2'h2;
  localparam logic [1:0] SEL_INIT = 2'h3;

  localparam logic [2:0] MUX_LOCK = 3'h1;
  localparam logic [2:0] MUX_FB   = 3'h2;
  localparam logic [2:0] MUX_REF  = 3'h4;

  // ---------------------------------------------------------------
  // lock detect timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int LOCK_SET_NS    = 15;
  localparam int LOCK_CLR_NS    = 25;
  localparam logic [GOOD_W-1:0] LOCK_RUN_SHORT = 3'h3;
  localparam logic [GOOD_W-1:0] LOCK_RUN_LONG  = 3'h5;

  // ---------------------------------------------------------------
  // register map and reset values
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] RLAT_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] NLAT_OFS   = 8'h0c;
  localparam logic [ADDR_W-1:0] FLAT_OFS   = 8'h10;
  localparam logic [ADDR_W-1:0] SHIFT_OFS  = 8'h14;
  localparam logic [SHIFT_W-1:0] LATCH_RST = 24'h000000;
  localparam logic               HOLD_RST  = 1'b0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [SHIFT_W-1:0] shift;
    logic [SHIFT_W-1:0] refLatch;
    logic [SHIFT_W-1:0] fbLatch;
    logic [SHIFT_W-1:0] funcLatch;
    logic [R_W-1:0]     refCnt;
    logic [N_W-1:0]     fbCnt;
    logic               refPulse;
    logic               fbPulse;
    logic               pfdUp;
    logic               pfdDn;
    logic [ERR_W-1:0]   errCnt;
    logic [GOOD_W-1:0]  goodCnt;
    logic               locked;
    logic               multiplexed_status_output;
    logic               cpUp;
    logic               cpDn;
    logic               cpOe;
    logic               powered;
  } core_s;

  typedef struct packed {
    logic              awHeld;
    logic              wHeld;
    logic [ADDR_W-1:0] awAddr;
    logic [31:0]       wData;
    logic              wByte0;
    logic              bValid;
    logic [1:0]        bResp;
    logic              rValid;
    logic [31:0]       rData;
    logic [1:0]        rResp;
    logic              counterHold;
  } bus_s;

endpackage : pll_dividers_pkg

// ==== hw/pll_dividers.sv ====
// digital section of a phase detector / synthesizer: serial load, latches, dividers, pfd
// assumes serial pins, chip enable, reference and rf inputs are asynchronous and far
// slower than sys_clk; an axi4-lite master sits on the register side
// Operation
// - every serial clock rising edge shifts the data bit into the 24-bit register
// - load strobe rising copies the shift register into one of four latches (the code keeps three: select 11 also loads the function latch)
// - chip enable low powers down and three-states the charge pump
// - chip enable high powers up only if the power-down bit is clear
// - mux output shows lock detect, divided feedback or divided reference
// - feedback divider is 13-bit, ratio 1 through 8191
// - reference divider is 14-bit, ratio 1 through 16383
// - phase detector compares reference over R against feedback over N
// - power-down disconnects the reference buffer; normally it stays connected
// - select 00 reference, 01 feedback, 10 function, 11 initialization latch
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module pll_dividers
  import pll_dividers_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              serialClk,
  input  wire logic              serialData,
  input  wire logic              latchLoadStrobe,
  input  wire logic              chipEnable,
  input  wire logic              referenceInput,
  input  wire logic              rfInput,
  output logic                   chargePumpUp,
  output logic                   chargePumpDown,
  output logic                   chargePumpOe,
  output logic                   referenceBufferConnect,
  output logic                   multiplexedStatusOutput,
  output logic                   poweredUp,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // bit order: 0 sclk, 1 data, 2 strobe, 3 ce, 4 ref, 5 rf
  logic [5:0] pinMeta;
  logic [5:0] pinSync;
  logic [5:0] pinPrev;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pinMeta <= 6'h00;
      pinSync <= 6'h00;
      pinPrev <= 6'h00;
    end else begin
      pinMeta <= {rfInput, referenceInput, chipEnable, latchLoadStrobe, serialData, serialClk};
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  wire sclkRise   = pinSync[0] & ~pinPrev[0];
  wire strobeRise = pinSync[2] & ~pinPrev[2];
  wire ceSync     = pinSync[3];
  wire refRise    = pinSync[4] & ~pinPrev[4];
  wire rfRise     = pinSync[5] & ~pinPrev[5];

  core_s core_q;
  core_s core_d;
  bus_s  bus_q;
  bus_s  bus_d;
  // ---------------------------------------------------------------
  // core: serial load, dividers, pfd, lock detect
  // ---------------------------------------------------------------
  logic              holdCounters;
  logic              upNext;
  logic              dnNext;
  wire [R_W-1:0]     refRatio   = core_q.refLatch[R_LSB +: R_W];
  wire [N_W-1:0]     fbRatio    = core_q.fbLatch[N_LSB +: N_W];
  // ratio 0 is not a legal setting; treated as divide-by-one
  wire [R_W-1:0]     refRatioM1 = (refRatio == '0) ? '0 : refRatio - R_W'(1);
  wire [N_W-1:0]     fbRatioM1  = (fbRatio == '0) ? '0 : fbRatio - N_W'(1);
  wire [2:0]         muxSel     = core_q.funcLatch[MUX_LSB +: 3];
  wire [GOOD_W-1:0]  goodNeed   = core_q.refLatch[LOCK_PREC] ? LOCK_RUN_LONG : LOCK_RUN_SHORT;

  always_comb begin
    core_d = core_q;
    if (sclkRise) begin
      core_d.shift = {core_q.shift[SHIFT_W-2:0], pinSync[1]};
    end
    if (strobeRise) begin
      unique case (core_q.shift[SEL_LSB +: 2])
        SEL_REF:  core_d.refLatch  = core_q.shift;
        SEL_FB:   core_d.fbLatch   = core_q.shift;
        SEL_FUNC: core_d.funcLatch = core_q.shift;
        SEL_INIT: core_d.funcLatch = core_q.shift;
      endcase
    end
    core_d.powered = ceSync & ~core_q.funcLatch[PWRDN_BIT];
    holdCounters = ~core_q.powered | core_q.funcLatch[CTR_RST_BIT] | bus_q.counterHold;
    core_d.refPulse = 1'b0;
    core_d.fbPulse  = 1'b0;
    if (holdCounters) begin
      core_d.refCnt = '0;
      core_d.fbCnt  = '0;
    end else begin
      if (refRise && core_q.refCnt >= refRatioM1) begin
        core_d.refCnt   = '0;
        core_d.refPulse = 1'b1;
      end else if (refRise) begin
        core_d.refCnt = core_q.refCnt + R_W'(1);
      end
      if (rfRise && core_q.fbCnt >= fbRatioM1) begin
        core_d.fbCnt   = '0;
        core_d.fbPulse = 1'b1;
      end else if (rfRise) begin
        core_d.fbCnt = core_q.fbCnt + N_W'(1);
      end
    end
    // both flags set means the edges met: clear together, score the gap
    upNext = core_q.pfdUp | core_q.refPulse;
    dnNext = core_q.pfdDn | core_q.fbPulse;
    if (upNext & dnNext) begin
      core_d.pfdUp  = 1'b0;
      core_d.pfdDn  = 1'b0;
      core_d.errCnt = '0;
      if (32'(core_q.errCnt) * CLK_PERIOD_NS > LOCK_CLR_NS) begin
        core_d.goodCnt = '0;
        core_d.locked  = 1'b0;
      end else if (32'(core_q.errCnt) * CLK_PERIOD_NS < LOCK_SET_NS) begin
        if (core_q.goodCnt + GOOD_W'(1) >= goodNeed) begin
          core_d.locked = 1'b1;
        end else begin
          core_d.goodCnt = core_q.goodCnt + GOOD_W'(1);
        end
      end
    end else begin
      core_d.pfdUp  = upNext;
      core_d.pfdDn  = dnNext;
      if ((upNext | dnNext) && core_q.errCnt != '1) begin
        core_d.errCnt = core_q.errCnt + ERR_W'(1);
      end
    end
    if (holdCounters) begin
      core_d.pfdUp   = 1'b0;
      core_d.pfdDn   = 1'b0;
      core_d.errCnt  = '0;
      core_d.goodCnt = '0;
      core_d.locked  = 1'b0;
    end
    core_d.cpOe = core_q.powered & ~core_q.funcLatch[CP_TRI_BIT];
    core_d.cpUp = core_d.pfdUp & core_d.cpOe;
    core_d.cpDn = core_d.pfdDn & core_d.cpOe;
    unique case (muxSel)
      MUX_LOCK: core_d.multiplexed_status_output = core_d.locked;
      MUX_FB:   core_d.multiplexed_status_output = core_d.fbPulse;
      MUX_REF:  core_d.multiplexed_status_output = core_d.refPulse;
      default:  core_d.multiplexed_status_output = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      core_q <= '{refLatch: LATCH_RST, fbLatch: LATCH_RST, funcLatch: LATCH_RST, default: '0};
    end else begin
      core_q <= core_d;
    end
  end

  assign chargePumpUp            = core_q.cpUp;
  assign chargePumpDown          = core_q.cpDn;
  assign chargePumpOe            = core_q.cpOe;
  assign referenceBufferConnect  = core_q.powered;
  assign poweredUp               = core_q.powered;
  assign multiplexedStatusOutput = core_q.multiplexed_status_output;

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  function automatic logic regHit(input logic [ADDR_W-1:0] a);
    regHit = (a == CTRL_OFS) || (a == STATUS_OFS) || (a == RLAT_OFS) ||
             (a == NLAT_OFS) || (a == FLAT_OFS) || (a == SHIFT_OFS);
  endfunction : regHit
  logic [31:0] readMux;
  always_comb begin
    bus_d = bus_q;
    unique case (s_axi_araddr)
      CTRL_OFS:   readMux = {31'h0, bus_q.counterHold};
      STATUS_OFS: readMux = {26'h0, core_q.locked, core_q.cpOe, core_q.pfdDn,
                             core_q.pfdUp, core_q.multiplexed_status_output, core_q.powered};
      RLAT_OFS:   readMux = {8'h00, core_q.refLatch};
      NLAT_OFS:   readMux = {8'h00, core_q.fbLatch};
      FLAT_OFS:   readMux = {8'h00, core_q.funcLatch};
      SHIFT_OFS:  readMux = {8'h00, core_q.shift};
      default:    readMux = 32'h00000000;
    endcase
    if (s_axi_awvalid && s_axi_awready) begin
      bus_d.awHeld = 1'b1;
      bus_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      bus_d.wHeld  = 1'b1;
      bus_d.wData  = s_axi_wdata;
      bus_d.wByte0 = s_axi_wstrb[0];
    end
    if (bus_q.awHeld && bus_q.wHeld && !bus_q.bValid) begin
      bus_d.awHeld = 1'b0;
      bus_d.wHeld  = 1'b0;
      bus_d.bValid = 1'b1;
      bus_d.bResp  = regHit(bus_q.awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (bus_q.awAddr == CTRL_OFS && bus_q.wByte0) begin
        bus_d.counterHold = bus_q.wData[0];
      end
    end
    if (bus_q.bValid && s_axi_bready) begin
      bus_d.bValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      bus_d.rValid = 1'b1;
      bus_d.rData  = readMux;
      bus_d.rResp  = regHit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (bus_q.rValid && s_axi_rready) begin
      bus_d.rValid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bus_q <= '{counterHold: HOLD_RST, default: '0};
    end else begin
      bus_q <= bus_d;
    end
  end

  // ready flops mirror the hold flags so every bus output comes from a register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= ~bus_d.awHeld & ~bus_d.bValid;
      s_axi_wready  <= ~bus_d.wHeld & ~bus_d.bValid;
      s_axi_arready <= ~bus_d.rValid;
    end
  end

  assign s_axi_bvalid = bus_q.bValid;
  assign s_axi_bresp  = bus_q.bResp;
  assign s_axi_rvalid = bus_q.rValid;
  assign s_axi_rdata  = bus_q.rData;
  assign s_axi_rresp  = bus_q.rResp;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence loadRefSeq;
    strobeRise && core_q.shift[1:0] == SEL_REF;
  endsequence
  shift_in_a: assert property (sclkRise |=> core_q.shift ==
    {$past(core_q.shift[SHIFT_W-2:0]), $past(pinSync[1])}) else $error("shift missed a bit");
  ref_load_a: assert property (loadRefSeq |=> core_q.refLatch == $past(core_q.shift))
    else $error("reference latch not loaded");
  fb_select_a: assert property (strobeRise && core_q.shift[1:0] == SEL_FB |=>
    core_q.fbLatch == $past(core_q.shift) && $stable(core_q.refLatch))
    else $error("wrong latch selected");
  latch_hold_a: assert property (!strobeRise |=> $stable(core_q.refLatch) &&
    $stable(core_q.fbLatch) && $stable(core_q.funcLatch)) else $error("latch moved mid-word");
  ce_low_a: assert property (!ceSync |=> !poweredUp ##1 !chargePumpOe)
    else $error("charge pump driven while disabled");
  power_up_a: assert property (ceSync && !core_q.funcLatch[PWRDN_BIT] |=> poweredUp)
    else $error("did not power up");
  ref_buffer_a: assert property (!ceSync |=> !referenceBufferConnect)
    else $error("reference buffer state wrong");
  mux_fb_a: assert property ($past(muxSel) == MUX_FB |->
    multiplexedStatusOutput == core_q.fbPulse) else $error("mux not showing feedback");
  fb_wrap_a: assert property (core_q.fbPulse |-> core_q.fbCnt == '0)
    else $error("feedback divider pulse off terminal count");
  ref_wrap_a: assert property (core_q.refPulse |-> core_q.refCnt == '0)
    else $error("reference divider pulse off terminal count");
  pfd_excl_a: assert property (!(core_q.pfdUp && core_q.pfdDn))
    else $error("pfd up and down both held");

endmodule : pll_dividers

// ==== dv/serial_host_model.sv ====
// host side of the three-wire programming link: shifts a word msb first, then strobes
// assumes sys_clk at 10 MHz; link clock period is 8 sys_clk (800 ns), idle low
`timescale 1ns/1ps
module serial_host_model (
  input  wire logic        sys_clk,
  input  wire logic        start,
  input  wire logic [23:0] word,
  input  wire logic        doStrobe,
  output logic             serialClk,
  output logic             serialData,
  output logic             latchLoadStrobe,
  output logic             busy
);
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    latchLoadStrobe = 1'b0;
    busy = 1'b0;
  end
  always @(posedge sys_clk) begin
    if (start && !busy) begin
      busy <= 1'b1;
      for (int i = 23; i >= 0; i--) begin
        serialData <= word[i];
        repeat (4) @(posedge sys_clk);
        serialClk <= 1'b1;
        repeat (4) @(posedge sys_clk);
        serialClk <= 1'b0;
        // after the last bit show the inverse so a late sample is caught
        if (i == 0) serialData <= ~word[i];
      end
      repeat (4) @(posedge sys_clk);
      latchLoadStrobe <= doStrobe;
      repeat (4) @(posedge sys_clk);
      latchLoadStrobe <= 1'b0;
      busy <= 1'b0;
    end
  end
endmodule : serial_host_model

// ==== dv/test_pll_dividers.sv ====
// self-checking bench: axi4-lite master, serial host model, divider and lock scenarios
// assumes the design answers on the bus in bounded time and pins are slow vs sys_clk
`timescale 1ns/1ps
module test_pll_dividers;
  import pll_dividers_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, chipEnable = 1'b1, referenceInput = 1'b0, rfInput = 1'b0;
  logic serialClk, serialData, latchLoadStrobe, busy, start = 1'b0, doStrobe = 1'b1;
  logic [23:0] word = 24'h0;
  logic chargePumpUp, chargePumpDown, chargePumpOe, referenceBufferConnect;
  logic multiplexedStatusOutput, poweredUp;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdVal;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rdResp;
  int n_fail = 0, check_count = 0, pulseCount = 0, seed = 32'h7f13, ratio, pulseBase;
  logic [23:0] refWord, w;

  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (multiplexedStatusOutput === 1'b1) pulseCount <= pulseCount + 1;

  pll_dividers DUT (.sys_clk, .nrst, .serialClk, .serialData, .latchLoadStrobe, .chipEnable,
    .referenceInput, .rfInput, .chargePumpUp, .chargePumpDown, .chargePumpOe,
    .referenceBufferConnect, .multiplexedStatusOutput, .poweredUp, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  serial_host_model host (.sys_clk, .start, .word, .doStrobe, .serialClk, .serialData,
    .latchLoadStrobe, .busy);

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic timeout(input int t);
    if (t >= 200) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, t, 0);
      tally_and_finish();
    end
  endtask : timeout
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      t++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 200);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
    timeout(t);
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a);
    int t;
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      t++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 200);
    rdVal = s_axi_rdata;
    rdResp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
    timeout(t);
  endtask : axi_read
  task automatic send(input logic [23:0] v, input logic strobe);
    int t;
    t = 0;
    word <= v;
    doStrobe <= strobe;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (busy !== 1'b0 && t < 600);
    repeat (8) @(posedge sys_clk);
    timeout(t / 3);
  endtask : send
  task automatic pump(input int n, input logic r, input logic f);
    repeat (n) begin
      referenceInput <= r;
      rfInput <= f;
      repeat (4) @(posedge sys_clk);
      referenceInput <= 1'b0;
      rfInput <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask : pump
  function automatic logic [7:0] lat_ofs(input logic [1:0] s);
    return (s == SEL_REF) ? RLAT_OFS : (s == SEL_FB) ? NLAT_OFS : FLAT_OFS;
  endfunction : lat_ofs

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    axi_read(RLAT_OFS);
    chk(rdVal, 32'h0);
    axi_read(8'h18);
    chk({rdResp, rdVal[29:0]}, {RESP_SLVERR, 30'h0});
    for (int s = 0; s < 4; s++) begin
      w = $random(seed);
      w[1:0] = s[1:0];
      if (s >= 2) w[8:2] = 7'h0;
      if (s == 0) refWord = w;
      send(w, 1'b1);
      axi_read(SHIFT_OFS);
      chk(rdVal, {8'h0, w});
      axi_read(lat_ofs(s[1:0]));
      chk(rdVal, {8'h0, w});
    end
    w = $random(seed);
    w[1:0] = SEL_REF;
    send(w, 1'b0);
    axi_read(RLAT_OFS);
    chk(rdVal, {8'h0, refWord});
    chipEnable <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk({poweredUp, chargePumpOe, referenceBufferConnect}, 32'h0);
    chipEnable <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({poweredUp, referenceBufferConnect}, 32'h3);
    send(24'h00000a, 1'b1);
    chk({poweredUp, referenceBufferConnect}, 32'h0);
    for (int k = 0; k < 4; k++) begin
      ratio = (k < 2) ? 1 : 2 + ({$random(seed)} % 6);
      send(24'(k[0] ? ((ratio << N_LSB) | SEL_FB) : ((ratio << R_LSB) | SEL_REF)), 1'b1);
      send((24'(k[0] ? MUX_FB : MUX_REF) << MUX_LSB) | SEL_FUNC, 1'b1);
      axi_write(CTRL_OFS, 32'h1);
      axi_read(CTRL_OFS);
      chk(rdVal, 32'h1);
      pulseBase = pulseCount;
      axi_write(CTRL_OFS, 32'h0);
      pump(ratio * 4, !k[0], k[0]);
      repeat (20) @(posedge sys_clk);
      chk(pulseCount - pulseBase, 4);
    end
    send(24'h000004, 1'b1);
    send(24'h000105, 1'b1);
    send((24'(MUX_LOCK) << MUX_LSB) | SEL_INIT, 1'b1);
    pump(10, 1'b1, 1'b1);
    chk(multiplexedStatusOutput, 32'h1);
    axi_read(STATUS_OFS);
    chk(rdVal[5], 32'h1);
    pump(1, 1'b1, 1'b0);
    chk({chargePumpUp, chargePumpDown, chargePumpOe}, 32'h5);
    send((24'h1 << CP_TRI_BIT) | (24'h1 << CTR_RST_BIT) | SEL_FUNC, 1'b1);
    chk({chargePumpUp, chargePumpDown, chargePumpOe}, 32'h0);
    axi_read(STATUS_OFS);
    chk(rdVal[2], 32'h0);
    tally_and_finish();
  end
endmodule : test_pll_dividers
